/* pkg/alu_add_defs.vh */
// Behaviour
// - carry add: pair source, either accumulator
// - carry add takes two clock cycles
// - carry add is one program word
// - sum source, carry, destination; write back
// - clamp_on_bit saturates accumulator result on overflow; word result wraps
// - register operand: zero-pad, sign extend
// - word operand aligned to upper word
// - operand pair sign extended to 36 bits
// - accumulator source adds to other accumulator
// - carry exact only with sign-extended extension
// - accumulator sources give full 36-bit carry
// - saturation_hit bit 6: overflow or move limit
// - top_part_busy bit 5: extension in use
// - top_bit_flag bit 3: result msb
// - null_result_bit bit 2: result zero
// - sign_flip_bit bit 1: two's-complement overflow
// - borrow_out_bit bit 0: carry out of result
`ifndef ALU_ADD_DEFS_VH
`define ALU_ADD_DEFS_VH
`define ADDR_ACC_A_EXT 8'h00
`define ADDR_ACC_A_HI 8'h04
`define ADDR_ACC_A_LO 8'h08
`define ADDR_ACC_B_EXT 8'h0C
`define ADDR_ACC_B_HI 8'h10
`define ADDR_ACC_B_LO 8'h14
`define ADDR_PAIR_HI 8'h18
`define ADDR_PAIR_LO 8'h1C
`define ADDR_WORD_X 8'h20
`define ADDR_STATUS 8'h24
`define ADDR_CMD 8'h28
`define ADDR_IRQ_STAT 8'h2C
`define ADDR_IRQ_MASK 8'h30
`define OP_ADC 3'h0
`define OP_ADD_ACC 3'h1
`define OP_ADD_PAIR 3'h2
`define OP_ADD_WORD 3'h3
`define OP_ADD_TO_WORD 3'h4
`define CMD_GO_BIT 8
`define CMD_MOVE_LIMIT_BIT 9
`define CC_SAT 6
`define CC_EXT 5
`define CC_UNNORM 4
`define CC_MSB 3
`define CC_ZERO 2
`define CC_OVF 1
`define CC_CARRY 0
`define MODE_CLAMP 5
`define MODE_GROWTH 7
`define IRQ_DONE 0
`define IRQ_OVF 1
`define IRQ_CARRY 2
`define OP_CYCLES 2'h2
`define SAT_POS 36'h7FFFFFFFF
`define SAT_NEG 36'h800000000
`endif

/* verilog/accumulator_add_with_carry.v */
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "alu_add_defs.vh"
module accumulator_add_with_carry (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    output reg busy
);
    reg [35:0] acc_a;
    reg [35:0] acc_b;
    reg [15:0] pair_high_word;
    reg [15:0] pair_low_word;
    reg [15:0] word_x;
    reg [7:0] mode_bits;
    reg [7:0] flag_bits;
    reg [2:0] irq_stat;
    reg [2:0] irq_mask;
    reg [2:0] op;
    reg dest_b;
    reg move_limit;
    reg [1:0] cyc;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [35:0] next_acc;
    reg [15:0] next_word;
    reg [7:0] next_flags;
    reg [36:0] sum;
    reg [35:0] src;
    reg [35:0] dst;
    reg [16:0] wsum;
    reg ovf;
    reg [35:0] res;
    reg [31:0] rd;
    reg [2:0] ev;
    wire take;
    wire [7:0] a8;
    wire done;
    wire [15:0] dst_upper;
    wire upd_a;
    wire upd_b;
    wire upd_word;
    wire wr_a_ext;
    wire wr_a_hi;
    wire wr_a_lo;
    wire wr_b_ext;
    wire wr_b_hi;
    wire wr_b_lo;
    wire wr_pair_hi;
    wire wr_pair_lo;
    wire wr_word;
    wire wr_status;
    wire wr_cmd;
    wire wr_mask;
    wire wr_stat;

    function [35:0] sx32;
        input [31:0] v;
        begin
            sx32 = {{4{v[31]}}, v};
        end
    endfunction

    function ext_used;
        input [35:0] v;
        begin
            ext_used = ~((v[35:31] == 5'h00) | (v[35:31] == 5'h1F));
        end
    endfunction

    // writes during an operation are dropped to keep operands stable
    function wr_hit;
        input pend;
        input is_busy;
        input [7:0] a;
        input [7:0] want;
        begin
            wr_hit = pend & ~is_busy & (a == want);
        end
    endfunction

    function [7:0] acc_flags;
        input [7:0] old;
        input [36:0] s;
        input [35:0] r;
        input v;
        input lim;
        begin
            acc_flags = old;
            // sticky, so a limited move is not lost
            acc_flags[`CC_SAT] = old[`CC_SAT] | v | lim;
            acc_flags[`CC_EXT] = ext_used(r);
            acc_flags[`CC_UNNORM] = ~(r[31] ^ r[30]);
            acc_flags[`CC_MSB] = r[35];
            acc_flags[`CC_ZERO] = (r == 36'h000000000);
            acc_flags[`CC_OVF] = v;
            // exact only if extension holds sign of bit 31
            acc_flags[`CC_CARRY] = s[36];
        end
    endfunction

    // word destination: no extension, so ext flag stays clear
    function [7:0] word_flags;
        input [7:0] old;
        input [15:0] x;
        input [15:0] y;
        input lim;
        reg [16:0] w;
        reg v;
        begin
            w = {1'b0, x} + {1'b0, y};
            v = (x[15] == y[15]) & (w[15] != x[15]);
            word_flags = old;
            word_flags[`CC_SAT] = old[`CC_SAT] | v | lim;
            word_flags[`CC_EXT] = 1'b0;
            word_flags[`CC_UNNORM] = ~(w[15] ^ w[14]);
            word_flags[`CC_MSB] = w[15];
            word_flags[`CC_ZERO] = (w[15:0] == 16'h0000);
            word_flags[`CC_OVF] = v;
            word_flags[`CC_CARRY] = w[16];
        end
    endfunction

    assign take = hsel & hready & htrans[1];
    assign a8 = haddr[7:0];
    assign done = busy & (cyc == `OP_CYCLES - 2'h1);
    assign dst_upper = dest_b ? acc_b[31:16] : acc_a[31:16];
    assign upd_a = done & (op != `OP_ADD_TO_WORD) & ~dest_b;
    assign upd_b = done & (op != `OP_ADD_TO_WORD) & dest_b;
    assign upd_word = done & (op == `OP_ADD_TO_WORD);
    assign wr_a_ext = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_A_EXT);
    assign wr_a_hi = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_A_HI);
    assign wr_a_lo = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_A_LO);
    assign wr_b_ext = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_B_EXT);
    assign wr_b_hi = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_B_HI);
    assign wr_b_lo = wr_hit(wr_pend, busy, wr_addr, `ADDR_ACC_B_LO);
    assign wr_pair_hi = wr_hit(wr_pend, busy, wr_addr, `ADDR_PAIR_HI);
    assign wr_pair_lo = wr_hit(wr_pend, busy, wr_addr, `ADDR_PAIR_LO);
    assign wr_word = wr_hit(wr_pend, busy, wr_addr, `ADDR_WORD_X);
    assign wr_status = wr_hit(wr_pend, busy, wr_addr, `ADDR_STATUS);
    assign wr_cmd = wr_hit(wr_pend, busy, wr_addr, `ADDR_CMD);
    assign wr_mask = wr_hit(wr_pend, busy, wr_addr, `ADDR_IRQ_MASK);
    // status clears are taken even while busy
    assign wr_stat = wr_pend & (wr_addr == `ADDR_IRQ_STAT);

    always @* begin
        dst = dest_b ? acc_b : acc_a;
        src = 36'h000000000;
        case (op)
            `OP_ADC, `OP_ADD_PAIR: src = sx32({pair_high_word,
                pair_low_word});
            `OP_ADD_ACC: src = dest_b ? acc_a : acc_b;
            `OP_ADD_WORD: src = sx32({word_x, 16'h0000});
            default: src = 36'h000000000;
        endcase
        sum = {1'b0, dst} + {1'b0, src} +
            {36'h000000000, (op == `OP_ADC) & flag_bits[`CC_CARRY]};
        ovf = (src[35] == dst[35]) & (sum[35] != dst[35]);
        res = sum[35:0];
        if (ovf & mode_bits[`MODE_CLAMP]) begin
            res = dst[35] ? `SAT_NEG : `SAT_POS;
        end
        // only the upper slice of the accumulator takes part
        wsum = {1'b0, word_x} + {1'b0, dst_upper};
        next_acc = res;
        next_word = wsum[15:0];
        if (op == `OP_ADD_TO_WORD) begin
            next_flags = word_flags(flag_bits, word_x, dst_upper,
                move_limit);
        end else begin
            next_flags = acc_flags(flag_bits, sum, res, ovf, move_limit);
        end
    end

    always @* begin
        rd = 32'h00000000;
        case (a8)
            `ADDR_ACC_A_EXT: rd = {28'h0000000, acc_a[35:32]};
            `ADDR_ACC_A_HI: rd = {16'h0000, acc_a[31:16]};
            `ADDR_ACC_A_LO: rd = {16'h0000, acc_a[15:0]};
            `ADDR_ACC_B_EXT: rd = {28'h0000000, acc_b[35:32]};
            `ADDR_ACC_B_HI: rd = {16'h0000, acc_b[31:16]};
            `ADDR_ACC_B_LO: rd = {16'h0000, acc_b[15:0]};
            `ADDR_PAIR_HI: rd = {16'h0000, pair_high_word};
            `ADDR_PAIR_LO: rd = {16'h0000, pair_low_word};
            `ADDR_WORD_X: rd = {16'h0000, word_x};
            `ADDR_STATUS: rd = {16'h0000, mode_bits, flag_bits};
            `ADDR_CMD: rd = {22'h000000, move_limit, busy, 4'h0, dest_b, op};
            `ADDR_IRQ_STAT: rd = {29'h00000000, irq_stat};
            `ADDR_IRQ_MASK: rd = {29'h00000000, irq_mask};
            default: rd = 32'h00000000;
        endcase
    end

    always @* begin
        ev = 3'h0;
        ev[`IRQ_DONE] = done;
        ev[`IRQ_OVF] = done & next_flags[`CC_OVF];
        ev[`IRQ_CARRY] = done & next_flags[`CC_CARRY];
    end

    // zero wait states, so every data phase is a single cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= take & hwrite;
            wr_addr <= a8;
            if (take & ~hwrite) begin
                hrdata <= rd;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_a <= 36'h000000000;
        end else if (upd_a) begin
            acc_a <= next_acc;
        end else begin
            if (wr_a_ext) begin
                acc_a[35:32] <= hwdata[3:0];
            end
            if (wr_a_hi) begin
                acc_a[31:16] <= hwdata[15:0];
            end
            if (wr_a_lo) begin
                acc_a[15:0] <= hwdata[15:0];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_b <= 36'h000000000;
        end else if (upd_b) begin
            acc_b <= next_acc;
        end else begin
            if (wr_b_ext) begin
                acc_b[35:32] <= hwdata[3:0];
            end
            if (wr_b_hi) begin
                acc_b[31:16] <= hwdata[15:0];
            end
            if (wr_b_lo) begin
                acc_b[15:0] <= hwdata[15:0];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pair_high_word <= 16'h0000;
            pair_low_word <= 16'h0000;
        end else begin
            if (wr_pair_hi) begin
                pair_high_word <= hwdata[15:0];
            end
            if (wr_pair_lo) begin
                pair_low_word <= hwdata[15:0];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_x <= 16'h0000;
        end else if (upd_word) begin
            word_x <= next_word;
        end else if (wr_word) begin
            word_x <= hwdata[15:0];
        end
    end

    // ops touch only the flag byte, never mode_bits
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_bits <= 8'h00;
            flag_bits <= 8'h00;
        end else if (done) begin
            flag_bits <= next_flags;
        end else if (wr_status) begin
            mode_bits <= hwdata[15:8];
            flag_bits <= hwdata[7:0];
        end
    end

    // one command word starts the whole operation
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op <= `OP_ADC;
            dest_b <= 1'b0;
            move_limit <= 1'b0;
            cyc <= 2'h0;
            busy <= 1'b0;
        end else if (wr_cmd) begin
            op <= hwdata[2:0];
            dest_b <= hwdata[3];
            move_limit <= hwdata[`CMD_MOVE_LIMIT_BIT];
            busy <= hwdata[`CMD_GO_BIT];
            cyc <= 2'h0;
        end else if (done) begin
            busy <= 1'b0;
            cyc <= 2'h0;
        end else if (busy) begin
            cyc <= cyc + 2'h1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= 3'h0;
        end else if (wr_mask) begin
            irq_mask <= hwdata[2:0];
        end
    end

    // set wins over write-one-to-clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_stat) begin
                irq_stat <= (irq_stat & ~hwdata[2:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            // registered output, so irq trails the status by a cycle
            irq <= |(irq_stat & irq_mask);
        end
    end
endmodule

/* tb/acc_add_sva.sv */
`timescale 1ns/100ps
`include "alu_add_defs.vh"
module acc_add_sva (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq,
    input wire busy
);
    reg ph_wr;
    reg ph_rd;
    reg [7:0] ph_a;
    // go while busy is refused, so it must not count as a start
    wire go_hit = ph_wr && ph_a == `ADDR_CMD && hwdata[`CMD_GO_BIT] && !busy;
    wire ext_rd = ph_a == `ADDR_ACC_A_EXT || ph_a == `ADDR_ACC_B_EXT;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_a <= 8'h00;
        end else if (hready) begin
            ph_wr <= hsel && htrans[1] && hwrite;
            ph_rd <= hsel && htrans[1] && !hwrite;
            ph_a <= haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence two_busy;
        busy ##1 busy ##1 !busy;
    endsequence
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_busy_span: assert property ($rose(busy) |-> two_busy)
        else $error("busy span wrong");
    chk_go_start: assert property (go_hit |=> two_busy)
        else $error("go did not start an operation");
    chk_busy_cause: assert property ($rose(busy) |-> $past(go_hit))
        else $error("busy rose without go");
    chk_unmapped_zero: assert property
        (ph_rd && ph_a > `ADDR_IRQ_MASK |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_ext_width: assert property (ph_rd && ext_rd |-> hrdata[31:4] == 0)
        else $error("extension wider than four bits");
    chk_status_width: assert property
        (ph_rd && ph_a == `ADDR_STATUS |-> hrdata[31:16] == 16'h0000)
        else $error("status upper half not zero");
endmodule
bind accumulator_add_with_carry acc_add_sva u_sva (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .busy(busy));

/* tb/accumulator_add_with_carry_tb.sv */
`timescale 1ns/100ps
`include "alu_add_defs.vh"
module accumulator_add_with_carry_tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h00000000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h00000000;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, busy;
    integer mismatches = 0;
    integer n_checks = 0;
    integer i, k;
    reg [35:0] acc [0:1];
    reg [35:0] s, r, ra;
    reg [36:0] sum;
    reg [16:0] ws;
    reg [31:0] pr, rd;
    reg [15:0] wx;
    reg [7:0] mode, cc, fm, b;
    reg [2:0] op, msk, ist, im;
    reg dst, v, ml;
    accumulator_add_with_carry dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .busy(busy));
    initial forever #20 hclk = ~hclk;
    task check(input [35:0] seen, input [35:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {24'h000000, a};
            do @(posedge hclk); while (hreadyout !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            do @(posedge hclk); while (hreadyout !== 1'b1);
            rd = hrdata;
        end
    endtask
    // accumulators travel as three words: ext, upper, lower
    task acc_io(input w, input d, input [35:0] x);
        begin
            b = d ? `ADDR_ACC_B_EXT : `ADDR_ACC_A_EXT;
            bus(w, b, {28'h0000000, x[35:32]});
            ra[35:32] = rd[3:0];
            bus(w, b + 8'h04, {16'h0000, x[31:16]});
            ra[31:16] = rd[15:0];
            bus(w, b + 8'h08, {16'h0000, x[15:0]});
            ra[15:0] = rd[15:0];
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches = mismatches + 1;
        finish_test;
    end
    initial begin
        k = $urandom(32'hFAEF);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1, 8'h38, 32'hFFFFFFFF);
        for (k = 0; k < 16; k = k + 1) begin
            bus(0, k * 4, 32'h00000000);
            check(rd, 36'h0);
        end
        for (i = 0; i < 40; i = i + 1) begin
            op = i % 5;
            {dst, ml, msk} = $urandom;
            {pr, wx} = {$urandom, $urandom};
            {mode, cc} = $urandom & 16'h7FFF;
            for (k = 0; k < 2; k = k + 1) begin
                acc[k] = {$urandom, $urandom};
                // carry is only exact with a sign-extended destination
                if (op != 1 && (op != 0 || i < 20))
                    acc[k] = {{4{acc[k][31]}}, acc[k][31:0]};
                acc_io(1, k, acc[k]);
            end
            bus(1, `ADDR_PAIR_HI, {16'h0000, pr[31:16]});
            bus(1, `ADDR_PAIR_LO, {16'h0000, pr[15:0]});
            bus(1, `ADDR_WORD_X, {16'h0000, wx});
            bus(1, `ADDR_IRQ_STAT, 32'h00000007);
            bus(1, `ADDR_IRQ_MASK, {29'h0, msk});
            bus(1, `ADDR_STATUS, {16'h0000, mode, cc});
            check(irq, 0);
            s = op == 1 ? acc[!dst] : op == 3 ? {{4{wx[15]}}, wx, 16'h0000}
                : {{4{pr[31]}}, pr};
            sum = acc[dst] + s + (op == 0 && cc[0]);
            r = sum[35:0];
            v = acc[dst][35] == s[35] && r[35] != s[35];
            ist = {sum[36], v, 1'b1};
            im = 3'h7;
            fm = op == 0 && i >= 20 ? 8'h6E : 8'h6F;
            if (v && mode[5])
                r = acc[dst][35] ? `SAT_NEG : `SAT_POS;
            ws = wx + acc[dst][31:16];
            if (op == 4) begin
                v = wx[15] == acc[dst][31] && ws[15] != wx[15];
                cc = {cc[7], cc[6] | v | ml, 1'b0, cc[4], ws[15],
                    ws[15:0] == 16'h0000, v, ws[16]};
                ist = {ws[16], v, 1'b1};
            end else
                cc = {cc[7], cc[6] | v | ml, r[35:31] != 5'h00 &&
                    r[35:31] != 5'h1F, cc[4], r[35], r == 36'h0, v,
                    sum[36]};
            bus(1, `ADDR_CMD, {22'h0, ml, 1'b1, 4'h0, dst, op});
            // lands while busy, so it must be refused
            bus(1, op == 4 ? `ADDR_WORD_X : dst ? `ADDR_ACC_B_HI
                : `ADDR_ACC_A_HI, ~r[31:0]);
            #1;
            for (k = 0; k < 10 && busy === 1'b1; k = k + 1)
                @(posedge hclk);
            check(k < 10, 1);
            if (op == 4) begin
                bus(0, `ADDR_WORD_X, 32'h00000000);
                check(rd[15:0], ws[15:0]);
            end else begin
                acc_io(0, dst, 36'h0);
                check(ra, r);
            end
            bus(0, `ADDR_STATUS, 32'h00000000);
            check(rd[15:8], mode);
            check(rd[7:0] & fm, cc & fm);
            bus(0, `ADDR_IRQ_STAT, 32'h00000000);
            check(rd[2:0] & im, ist & im);
            check(irq, |(ist & msk));
        end
        finish_test;
    end
endmodule
